/* File: pwig_defs.svh */
// Address, field and reset constants for the port wake and interrupt gating block.
`ifndef PWIG_DEFS_SVH
`define PWIG_DEFS_SVH
// ==========================================================================
// Register indices; the bus byte address is four times the index.
`define PWIG_IDX_WAKE_EN    12'h017
`define PWIG_IDX_INT_STS    12'h01B
`define PWIG_IDX_INT_MSK    12'h01F
`define PWIG_IDX_WAKE_LAT   12'h0F0
// ==========================================================================
// Address field layout: [17:14] port number, [13:2] index, [1:0] zero.
`define PWIG_A_PORT_HI      17
`define PWIG_A_PORT_LO      14
`define PWIG_A_IDX_HI       13
`define PWIG_A_IDX_LO       2
`define PWIG_A_TOP_LO       18
`define PWIG_MAC_PORT_ID    4'h7
// ==========================================================================
// Bit positions: magic, link, energy in wake enable and latch; PTP, PHY, ACL in status and mask.
`define PWIG_B_MAGIC        2
`define PWIG_B_LINK         1
`define PWIG_B_ENERGY       0
`define PWIG_B_PTP          2
`define PWIG_B_PHY          1
`define PWIG_B_ACL          0
`define PWIG_FIELD_W        3
`define PWIG_RST3           3'h0
`define PWIG_RST32          32'h0000_0000
`define PWIG_HTRANS_NONSEQ  2'h2
`define PWIG_HSIZE_WORD     3'h2
`endif

/* File: pwig_pkg.sv */
// Shared types of the port wake and interrupt gating block.
package pwig_pkg;
    // ======================================================================
    // Register selected by the latched bus address.
    typedef enum logic [2:0] {
        PWIG_REG_NONE = 3'b000,
        PWIG_REG_WEN  = 3'b001,
        PWIG_REG_STS  = 3'b010,
        PWIG_REG_MSK  = 3'b011,
        PWIG_REG_WLAT = 3'b100
    } pwig_reg_t;
    // Bus slave phase.
    typedef enum logic [1:0] {
        PWIG_ST_IDLE = 2'b00,
        PWIG_ST_WR   = 2'b01,
        PWIG_ST_RD   = 2'b10
    } pwig_st_t;
endpackage

/* File: pwig_reg_if.sv */
// Register access bundle between the bus slave and one port unit.
`timescale 1ns/1ps
`default_nettype none
interface pwig_reg_if;
    import pwig_pkg::*;
    logic       wr_stb;   // One-cycle write strobe.
    pwig_reg_t  sel;      // Register addressed, for read and write.
    logic [7:0] wdata;    // Write byte.
    logic [7:0] rd_data;  // Read byte of the selected register.
    logic       irq_req;  // Unmasked status present on this port.
    logic       wake_req; // Enabled wake event latched on this port.
    modport ctrl (output wr_stb, sel, wdata, input rd_data, irq_req, wake_req);
    modport unit (input wr_stb, sel, wdata, output rd_data, irq_req, wake_req);
endinterface
`default_nettype wire

/* File: pwig_mp_match.sv */
// Magic packet destination address comparator for one port.
`timescale 1ns/1ps
`default_nettype none
`include "pwig_defs.svh"
module pwig_mp_match import pwig_pkg::*; #(
    parameter int MAC_W = 48
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Candidate magic packet and the switch address.
    input  wire logic             da_vld,
    input  wire logic [MAC_W-1:0] da,
    input  wire logic [MAC_W-1:0] switch_mac,
    // Registered one-cycle hit.
    output logic                  hit
);
    typedef struct packed {
        logic hit;
    } pwig_mm_t;
    pwig_mm_t s_r, s_nxt;

    // A packet counts only when its destination equals the switch address.
    always_comb begin
        s_nxt     = s_r;
        s_nxt.hit = da_vld && (da == switch_mac); // R2
    end

    // State register.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hit = s_r.hit;
endmodule
`default_nettype wire

/* File: pwig_port_unit.sv */
// Wake enable, interrupt mask, ACL status and wake latch of one port.
`timescale 1ns/1ps
`default_nettype none
`include "pwig_defs.svh"
module pwig_port_unit import pwig_pkg::*; #(
    parameter bit HAS_PHY = 1'b1
) (
    // Clock and reset.
    input  wire logic   core_clk,
    input  wire logic   sys_rst,
    // Events: one-cycle pulses.
    input  wire logic   magic_hit,
    input  wire logic   link_up_evt,
    input  wire logic   energy_evt,
    input  wire logic   acl_cnt_evt,
    // Summaries of the individual PTP and PHY interrupt registers: levels.
    input  wire logic   ptp_irq_lvl,
    input  wire logic   phy_irq_lvl,
    // Register access.
    pwig_reg_if.unit    rif
);
    typedef struct packed {
        logic [`PWIG_FIELD_W-1:0] wen;
        logic [`PWIG_FIELD_W-1:0] msk;
        logic [`PWIG_FIELD_W-1:0] wlat;
        logic                     acl;
    } pwig_pu_t;
    pwig_pu_t s_r, s_nxt;
    logic [`PWIG_FIELD_W-1:0] phy_only; // Bits that exist only on PHY ports.
    logic [`PWIG_FIELD_W-1:0] sts;      // Live status byte, low bits.
    logic [`PWIG_FIELD_W-1:0] evt;      // Raw wake events this cycle.

    // Link-up and energy detect have no meaning on the MAC port.
    assign phy_only = HAS_PHY ? 3'h7 : 3'h4;
    assign evt = {magic_hit, link_up_evt, energy_evt} & phy_only;
    // PTP and PHY summaries are forced low on the MAC port.
    assign sts = {ptp_irq_lvl & HAS_PHY, phy_irq_lvl & HAS_PHY, s_r.acl}; // R5 R6

    // Next state: software writes first, hardware sets last so a set wins.
    always_comb begin
        s_nxt = s_r;
        if (rif.wr_stb && rif.sel == PWIG_REG_WEN) begin
            s_nxt.wen = rif.wdata[`PWIG_FIELD_W-1:0] & phy_only; // R13
        end
        if (rif.wr_stb && rif.sel == PWIG_REG_MSK) begin
            s_nxt.msk = rif.wdata[`PWIG_FIELD_W-1:0]; // R13
            // A change of the ACL mask bit clears the ACL status.
            if (rif.wdata[`PWIG_B_ACL] != s_r.msk[`PWIG_B_ACL]) begin
                s_nxt.acl = 1'b0; // R9
            end
        end
        if (rif.wr_stb && rif.sel == PWIG_REG_WLAT) begin
            s_nxt.wlat = s_r.wlat & ~rif.wdata[`PWIG_FIELD_W-1:0];
        end
        // Only enabled events are latched toward the wake pin.
        s_nxt.wlat = s_nxt.wlat | (evt & s_r.wen); // R1 R3 R4
        if (acl_cnt_evt) begin
            s_nxt.acl = 1'b1; // R7
        end
    end

    // State register.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Read mux; bits 7:3 always read zero.
    always_comb begin
        case (rif.sel)
            PWIG_REG_WEN:  rif.rd_data = {5'h00, s_r.wen}; // R13
            PWIG_REG_STS:  rif.rd_data = {5'h00, sts};
            PWIG_REG_MSK:  rif.rd_data = {5'h00, s_r.msk};
            PWIG_REG_WLAT: rif.rd_data = {5'h00, s_r.wlat};
            default:       rif.rd_data = 8'h00;
        endcase
    end

    // Mask bits are active low enables, one per status bit; the PTP bit is
    // only a port-level gate over the already enabled timestamp summary.
    assign rif.irq_req  = |(sts & ~s_r.msk); // R10 R11 R12
    // Wake holds while an event is latched and still enabled.
    assign rif.wake_req = |(s_r.wlat & s_r.wen); // R15
endmodule
`default_nettype wire

/* File: pwig_top.sv */
// AHB-Lite register slave and port array of the wake and interrupt gating block.
// Operation
// R1: Magic packet wakes only when its enable set.
// R2: Magic packet must match switch MAC address.
// R3: Link-up wakes PHY port only when enabled.
// R4: Energy detect wakes PHY port when enabled.
// R5: PTP summary at status bit 2, PHY ports.
// R6: PHY summary at status bit 1, PHY ports.
// R7: ACL counter-mode entry sets ACL status bit.
// R8: ACL status and enable exist on every port.
// R9: Toggling ACL mask bit clears ACL status.
// R10: Mask bit zero enables, one disables source.
// R11: Mask bits gate status bits position by position.
// R12: PTP mask is only a port-level gate.
// R13: Bits 7 to 3 read zero, ignore writes.
// R14: MAC port addressed as 7, PHYs 1-4.
// R15: Wake pin follows latched events; irq ORs unmasked.
`timescale 1ns/1ps
`default_nettype none
`include "pwig_defs.svh"
module pwig_top import pwig_pkg::*; #(
    parameter int NUM_PHY_PORTS = 4,  // Ports with an integrated PHY.
    parameter int MAC_W         = 48, // Width of a MAC address.
    parameter int NP            = NUM_PHY_PORTS + 1
) (
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // AHB-Lite slave.
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Switch address for magic packet matching.
    input  wire logic [MAC_W-1:0]  switch_mac,
    // Per-port candidate magic packets, flattened by port slot.
    input  wire logic [NP-1:0]       mp_da_vld,
    input  wire logic [NP*MAC_W-1:0] mp_da,
    // Per-port event pulses.
    input  wire logic [NP-1:0]     link_up_evt,
    input  wire logic [NP-1:0]     energy_evt,
    input  wire logic [NP-1:0]     acl_cnt_evt,
    // Per-port interrupt summary levels.
    input  wire logic [NP-1:0]     ptp_irq_lvl,
    input  wire logic [NP-1:0]     phy_irq_lvl,
    // Outputs to power management and the interrupt controller.
    output logic                   power_wake_event_pin,
    output logic                   port_irq
);
    localparam int SW = $clog2(NP + 1); // Slot width; value NP means none.

    // ======================================================================
    // Decoding helpers
    // ======================================================================

    // Maps the port field of an address to a slot; slots 0 to
    // NUM_PHY_PORTS-1 are ports 1 upward, the last slot is the MAC port.
    function automatic logic [SW-1:0] port_slot(input logic [31:0] a);
        logic [3:0] id;
        id = a[`PWIG_A_PORT_HI:`PWIG_A_PORT_LO];
        port_slot = SW'(NP);
        if (id == `PWIG_MAC_PORT_ID) begin
            port_slot = SW'(NP - 1); // R14
        end else if (id != 4'h0 && 32'(id) <= NUM_PHY_PORTS) begin
            port_slot = SW'(32'(id) - 1); // R14
        end
    endfunction

    // Maps the register index of an address to a register.
    function automatic pwig_reg_t reg_sel(input logic [31:0] a);
        case (a[`PWIG_A_IDX_HI:`PWIG_A_IDX_LO])
            `PWIG_IDX_WAKE_EN:  reg_sel = PWIG_REG_WEN;
            `PWIG_IDX_INT_STS:  reg_sel = PWIG_REG_STS;
            `PWIG_IDX_INT_MSK:  reg_sel = PWIG_REG_MSK;
            `PWIG_IDX_WAKE_LAT: reg_sel = PWIG_REG_WLAT;
            default:            reg_sel = PWIG_REG_NONE;
        endcase
    endfunction

    // ======================================================================
    // State
    // ======================================================================

    typedef struct packed {
        pwig_st_t    st;     // Data phase in progress.
        logic [SW-1:0] slot; // Port slot of the latched address.
        pwig_reg_t   sel;    // Register of the latched address.
        logic [31:0] rdata;  // Read data driven onto hrdata.
        logic        ready;  // Drives hreadyout.
        logic        irq;    // Registered interrupt output.
        logic        wake;   // Registered wake output.
    } pwig_top_t;

    pwig_top_t s_r;   // Registered state.
    pwig_top_t s_nxt; // Next state.

    logic [NP-1:0] irq_vec;          // Per-port unmasked status.
    logic [NP-1:0] wake_vec;         // Per-port latched enabled wake.
    logic [NP-1:0] magic_hit;        // Per-port matched magic packets.
    logic [7:0]    rd_byte [NP];     // Per-port read data.
    logic          addr_ok;          // Address phase is a legal word access.
    logic          take;             // Address phase accepted this edge.
    logic [7:0]    rd_val;           // Read byte of the latched address.

    // ======================================================================
    // Port array
    // ======================================================================

    // Every slot, the MAC port included, gets the full unit; PHY-only
    // bits are disabled inside the unit for the MAC slot.
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_port
            pwig_reg_if rif ();

            // Writes land only in the data phase of a write to this slot.
            assign rif.wr_stb = (s_r.st == PWIG_ST_WR) && (s_r.slot == SW'(gi));
            assign rif.sel    = s_r.sel;
            assign rif.wdata  = hwdata[7:0];
            assign rd_byte[gi]  = rif.rd_data;
            assign irq_vec[gi]  = rif.irq_req;
            assign wake_vec[gi] = rif.wake_req;

            // Destination compare for this port.
            pwig_mp_match #(
                .MAC_W      (MAC_W)
            ) u_match (
                .core_clk   (core_clk),
                .sys_rst    (sys_rst),
                .da_vld     (mp_da_vld[gi]),
                .da         (mp_da[gi*MAC_W +: MAC_W]),
                .switch_mac (switch_mac),
                .hit        (magic_hit[gi])
            );

            // Registers of this port.
            pwig_port_unit #(
                .HAS_PHY     (gi < NUM_PHY_PORTS)
            ) u_unit ( // R8
                .core_clk    (core_clk),
                .sys_rst     (sys_rst),
                .magic_hit   (magic_hit[gi]),
                .link_up_evt (link_up_evt[gi]),
                .energy_evt  (energy_evt[gi]),
                .acl_cnt_evt (acl_cnt_evt[gi]),
                .ptp_irq_lvl (ptp_irq_lvl[gi]),
                .phy_irq_lvl (phy_irq_lvl[gi]),
                .rif         (rif)
            );
        end
    endgenerate

    // ======================================================================
    // Bus slave
    // ======================================================================

    // Only whole aligned words with clear upper address bits are mapped;
    // anything else completes OKAY, reads zero and writes nothing.
    assign addr_ok = (haddr[1:0] == 2'h0) && (hsize == `PWIG_HSIZE_WORD)
                   && (haddr[31:`PWIG_A_TOP_LO] == 14'h0000);

    // A transfer starts on a NONSEQ address phase seen with hready high.
    assign take = hsel && hready && (htrans == `PWIG_HTRANS_NONSEQ);

    // Read byte of the latched address; an unmapped slot reads zero.
    always_comb begin
        rd_val = 8'h00;
        if (s_r.slot < SW'(NP)) begin
            rd_val = rd_byte[s_r.slot];
        end
    end

    // Next state. Writes are zero-wait: the unit commits at the end of the
    // data phase. Reads take one wait state so that a read right after a
    // write already sees the written value.
    always_comb begin
        s_nxt = s_r;
        // Interrupt and wake outputs are ORs over all ports.
        s_nxt.irq  = |irq_vec;  // R11 R15
        s_nxt.wake = |wake_vec; // R15
        case (s_r.st)
            PWIG_ST_WR: begin
                s_nxt.st = PWIG_ST_IDLE;
            end
            PWIG_ST_RD: begin
                // Wait state ends; the data stand until the next read.
                s_nxt.rdata = {24'h000000, rd_val};
                s_nxt.ready = 1'b1;
                s_nxt.st    = PWIG_ST_IDLE;
            end
            default: begin
                s_nxt.st = PWIG_ST_IDLE;
            end
        endcase
        // A new address phase may overlap the end of a previous data phase.
        if (take) begin
            s_nxt.slot = addr_ok ? port_slot(haddr) : SW'(NP);
            s_nxt.sel  = addr_ok ? reg_sel(haddr) : PWIG_REG_NONE;
            if (hwrite) begin
                s_nxt.st = PWIG_ST_WR;
            end else begin
                s_nxt.st    = PWIG_ST_RD;
                s_nxt.ready = 1'b0;
            end
        end
    end

    // State register; the slave is ready and idle out of reset.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r       <= '0;
            s_r.st    <= PWIG_ST_IDLE;
            s_r.sel   <= PWIG_REG_NONE;
            s_r.slot  <= SW'(NP);
            s_r.rdata <= `PWIG_RST32;
            s_r.ready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================================
    // Outputs, all straight from flip-flops except hresp, which is tied low
    // ======================================================================

    assign hrdata               = s_r.rdata;
    assign hreadyout            = s_r.ready;
    assign hresp                = 1'b0;
    assign power_wake_event_pin = s_r.wake;
    assign port_irq             = s_r.irq;
endmodule
`default_nettype wire

/* File: pwig_host.sv */
// Behavioural host power management and interrupt controller watching the block.
`timescale 1ns/1ps
`default_nettype none
module pwig_host (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Wake pin and interrupt line from the block.
    input  wire logic       wake_pin,
    input  wire logic       irq,
    // What the host has seen.
    output logic [7:0]      wake_cnt,
    output logic            irq_seen
);
    logic pin_q; // Last sampled pin level.
    // ==========================================================
    // Count wake requests: each rising edge is one wake-up.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_q    <= 1'h0;
            wake_cnt <= 8'h00;
            irq_seen <= 1'h0;
        end else begin
            pin_q <= wake_pin;
            if (wake_pin && !pin_q) begin
                wake_cnt <= wake_cnt + 8'h01;
            end
            if (irq) begin
                irq_seen <= 1'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: pwig_top_assertions.sv */
// Port checker of the wake and interrupt gating block.
`timescale 1ns/1ps
`default_nettype none
module pwig_chk #(
    parameter int NP = 5
) (
    // Observed ports.
    input  wire logic          core_clk,
    input  wire logic          sys_rst,
    input  wire logic          hsel,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic          hready,
    input  wire logic [31:0]   hrdata,
    input  wire logic          hreadyout,
    input  wire logic          hresp,
    input  wire logic [NP-1:0] mp_da_vld,
    input  wire logic [NP-1:0] link_up_evt,
    input  wire logic [NP-1:0] energy_evt,
    input  wire logic          power_wake_event_pin,
    input  wire logic          port_irq
);
    logic rt; // Read taken at this edge.
    logic wt; // Write taken at this edge.
    assign rt = hsel && hready && htrans == 2'h2 && !hwrite;
    assign wt = hsel && hready && htrans == 2'h2 && hwrite;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Bus timing and register content.
    property p_rd_wait; rt |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_nowait; wt |=> hreadyout; endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_okay; hresp == 1'h0; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_rd_hold; !$rose(hreadyout) |-> $stable(hrdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_hi_zero; hrdata[31:3] == 29'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("reserved bits set");
    // ==========================================================
    // Wake pin and interrupt behaviour; a cleared wake must come from a write.
    property p_rst_quiet; $fell(sys_rst) |-> !power_wake_event_pin && !port_irq && hreadyout; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not idle");
    property p_pin_cause;
        $rose(power_wake_event_pin) |-> $past(|(link_up_evt | energy_evt), 2) || $past(|mp_da_vld, 3);
    endproperty
    a_pin_cause: assert property (p_pin_cause) else $error("wake without event");
    property p_pin_fall; $fell(power_wake_event_pin) |-> $past(wt, 3); endproperty
    a_pin_fall: assert property (p_pin_fall) else $error("wake dropped alone");
    c_read: cover property (rt);
    c_pin: cover property ($rose(power_wake_event_pin));
    c_irq: cover property ($rose(port_irq));
endmodule
bind pwig_top pwig_chk #(.NP(NP)) u_chk (.core_clk, .sys_rst, .hsel, .htrans, .hwrite, .hready,
    .hrdata, .hreadyout, .hresp, .mp_da_vld, .link_up_evt, .energy_evt, .power_wake_event_pin, .port_irq);
`default_nettype wire

/* File: port_wake_and_interrupt_gating_tb.sv */
// Self-checking bench of the wake and interrupt gating block.
`timescale 1ns/1ps
`default_nettype none
`include "pwig_defs.svh"
module port_wake_and_interrupt_gating_tb;
    logic        core_clk = 0;
    logic        sys_rst = 1;
    logic        hsel = 0;
    logic        hwrite = 0;
    logic [31:0] haddr = 0;
    logic [31:0] hwdata = 0;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin;
    logic        irq;
    logic [47:0] mac = 48'h0A1B_2C3D_4E5F; // Switch address.
    logic [239:0] mda;
    logic [4:0]  mvld = 0, lnk = 0, eng = 0, acl = 0, ptp = 0, phy = 0;
    logic [7:0]  wcnt;
    logic        iseen;
    int          n_errors = 0;
    int          cmp_count = 0;
    always #12.5 core_clk = ~core_clk;
    pwig_top DUT (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .switch_mac(mac), .mp_da_vld(mvld),
        .mp_da(mda), .link_up_evt(lnk), .energy_evt(eng), .acl_cnt_evt(acl), .ptp_irq_lvl(ptp),
        .phy_irq_lvl(phy), .power_wake_event_pin(pin), .port_irq(irq));
    pwig_host host (.core_clk, .sys_rst, .wake_pin(pin), .irq, .wake_cnt(wcnt), .irq_seen(iseen));
    // ==========================================================
    // Shared helpers; all are entered just after a rising edge.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Wait for hready as long as it takes; only the watchdog ends a dead wait.
    task automatic wt_rdy();
        do @(posedge core_clk); while (hreadyout !== 1'b1);
    endtask
    task automatic bus(input logic w, input logic [3:0] p, input logic [11:0] ix,
                       input logic [7:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {14'h0, p, ix, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        wt_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wt_rdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [3:0] p, input logic [11:0] ix, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, p, ix, d, q);
    endtask
    task automatic rdc(input string nm, input logic [3:0] p, input logic [11:0] ix, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, p, ix, 8'h00, q);
        chk(nm, {24'h0, e}, q);
    endtask
    // One-cycle event: 0 energy, 1 link, 2 magic packet, 3 ACL counter.
    task automatic ev(input int k, input int s);
        case (k)
            0: eng[s] <= 1'b1;
            1: lnk[s] <= 1'b1;
            2: mvld[s] <= 1'b1;
            default: acl[s] <= 1'b1;
        endcase
        @(posedge core_clk);
        {mvld, lnk, eng, acl} <= 20'h0;
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_regs();
        for (int i = 0; i < 2; i++) begin
            rdc("wake_en rst", i ? 4'h7 : 4'h1, `PWIG_IDX_WAKE_EN, 8'h00);
            rdc("status rst", i ? 4'h7 : 4'h1, `PWIG_IDX_INT_STS, 8'h00);
            rdc("mask rst", i ? 4'h7 : 4'h1, `PWIG_IDX_INT_MSK, 8'h00);
        end
        wr(4'h1, `PWIG_IDX_WAKE_EN, 8'hFF);
        rdc("wake_en rsv", 4'h1, `PWIG_IDX_WAKE_EN, 8'h07);
        wr(4'h7, `PWIG_IDX_WAKE_EN, 8'hFF);
        rdc("mac wake_en", 4'h7, `PWIG_IDX_WAKE_EN, 8'h04);
        wr(4'h7, `PWIG_IDX_INT_MSK, 8'hFF);
        rdc("mask rsv", 4'h7, `PWIG_IDX_INT_MSK, 8'h07);
        wr(4'h7, `PWIG_IDX_INT_MSK, 8'h00);
        wr(4'h5, `PWIG_IDX_WAKE_EN, 8'h07);
        rdc("port five", 4'h5, `PWIG_IDX_WAKE_EN, 8'h00);
        hsize <= 3'h0;
        wr(4'h1, `PWIG_IDX_WAKE_EN, 8'h00);
        hsize <= 3'h2;
        rdc("byte write", 4'h1, `PWIG_IDX_WAKE_EN, 8'h07);
        rdc("unmapped", 4'h1, 12'h018, 8'h00);
        $display("t_regs done");
    endtask
    // Each wake source: off when disabled, on when enabled, off when cleared.
    task automatic t_wake();
        for (int k = 0; k < 3; k++) begin
            wr(4'h1, `PWIG_IDX_WAKE_EN, 8'h00);
            ev(k, 0);
            cyc(4);
            chk("pin disabled", 0, pin);
            wr(4'h1, `PWIG_IDX_WAKE_EN, 8'h01 << k);
            if (k == 2) begin
                mda[47:0] <= ~mac;
                ev(k, 0);
                cyc(4);
                chk("pin foreign da", 0, pin);
                mda[47:0] <= mac;
            end
            ev(k, 0);
            cyc(4);
            chk("pin enabled", 1, pin);
            wr(4'h1, 12'h0F0, 8'h01 << k);
            cyc(3);
            chk("pin cleared", 0, pin);
        end
        wr(4'h1, `PWIG_IDX_WAKE_EN, 8'h02);
        ev(1, 0);
        cyc(4);
        wr(4'h1, `PWIG_IDX_WAKE_EN, 8'h00);
        cyc(3);
        chk("pin enable off", 0, pin);
        wr(4'h7, `PWIG_IDX_WAKE_EN, 8'hFF);
        ev(1, 4);
        cyc(4);
        chk("pin mac link", 0, pin);
        wr(4'h7, `PWIG_IDX_WAKE_EN, 8'h00);
        $display("t_wake done");
    endtask
    task automatic t_irq();
        ptp[1] <= 1'b1;
        cyc(2);
        rdc("sts ptp", 4'h2, `PWIG_IDX_INT_STS, 8'h04);
        chk("irq ptp", 1, irq);
        wr(4'h2, `PWIG_IDX_INT_MSK, 8'h04);
        cyc(2);
        chk("irq ptp masked", 0, irq);
        phy[1] <= 1'b1;
        cyc(2);
        rdc("sts phy", 4'h2, `PWIG_IDX_INT_STS, 8'h06);
        chk("irq phy", 1, irq);
        wr(4'h2, `PWIG_IDX_INT_MSK, 8'h06);
        ptp[4] <= 1'b1;
        phy[4] <= 1'b1;
        cyc(2);
        rdc("sts mac", 4'h7, `PWIG_IDX_INT_STS, 8'h00);
        chk("irq all masked", 0, irq);
        {ptp, phy} <= 10'h0;
        wr(4'h2, `PWIG_IDX_INT_MSK, 8'h00);
        $display("t_irq done");
    endtask
    task automatic t_acl();
        ev(3, 4);
        cyc(2);
        rdc("sts acl", 4'h7, `PWIG_IDX_INT_STS, 8'h01);
        chk("irq acl", 1, irq);
        wr(4'h7, `PWIG_IDX_INT_MSK, 8'h01);
        rdc("acl toggled", 4'h7, `PWIG_IDX_INT_STS, 8'h00);
        ev(3, 4);
        cyc(2);
        rdc("acl again", 4'h7, `PWIG_IDX_INT_STS, 8'h01);
        chk("irq acl masked", 0, irq);
        wr(4'h7, `PWIG_IDX_INT_MSK, 8'h00);
        rdc("acl toggled back", 4'h7, `PWIG_IDX_INT_STS, 8'h00);
        chk("host wakes", 4, {24'h0, wcnt});
        chk("host irq", 1, iseen);
        $display("t_acl done");
    endtask
    // ==========================================================
    // The single place where the run ends.
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        mda = {5{48'h0A1B_2C3D_4E5F}};
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_wake();
        t_irq();
        t_acl();
        stop_test();
    end
    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        #(25 * 20000);
        n_errors++;
        $display("watchdog expired");
        stop_test();
    end
endmodule
`default_nettype wire
